// file: rtl/mpsd_consts.vh
// Shared constants for the multimode pulse and density modulator
`ifndef MPSD_CONSTS_VH
`define MPSD_CONSTS_VH

// Register indices; byte address is four times the index
`define MPSD_IDX_CTRL        10'h0ae
`define MPSD_IDX_PW_LO       10'h0b1
`define MPSD_IDX_PW_HI       10'h0b2
`define MPSD_IDX_CW_LO       10'h0b3
`define MPSD_IDX_CW_HI       10'h0b4
`define MPSD_IDX_STATUS      10'h0b5

// APB address width in bits
`define MPSD_ADDR_W          12

// Reset values
`define MPSD_RST_CTRL        7'h00
`define MPSD_RST_BYTE        8'h00

// Control field positions
`define MPSD_MODE_HI         6
`define MPSD_MODE_LO         4
`define MPSD_DIV_HI          3
`define MPSD_DIV_LO          2
`define MPSD_SRC_HI          1
`define MPSD_SRC_LO          0

// Mode codes
`define MPSD_MODE_OFF        3'h0
`define MPSD_MODE_SINGLE16   3'h1
`define MPSD_MODE_TWIN8      3'h2
`define MPSD_MODE_TWIN16     3'h3
`define MPSD_MODE_DENS_NRZ   3'h4
`define MPSD_MODE_DUAL8      3'h5
`define MPSD_MODE_DENS_RZ    3'h6
`define MPSD_MODE_PARK       3'h7

// Clock source codes
`define MPSD_SRC_XTAL_DIV    2'h0
`define MPSD_SRC_RTC         2'h1
`define MPSD_SRC_EXT_PIN     2'h2
`define MPSD_SRC_CORE        2'h3

// Prescaler terminal counts for divide by 1, 4, 16 and 64
`define MPSD_DIV1_LAST       6'h00
`define MPSD_DIV4_LAST       6'h03
`define MPSD_DIV16_LAST      6'h0f
`define MPSD_DIV64_LAST      6'h3f

// Fixed top of the free running counter
`define MPSD_CNT_TOP         16'hffff

`endif

// file: rtl/mpsd_prescale.v
// Clock source selection and prescaler producing PWM clock enables
`timescale 1ns/1ps
`include "mpsd_consts.vh"

module mpsd_prescale (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       clear,          // Restart the divider
	input  wire [1:0] src_sel,        // Clock source code
	input  wire [1:0] div_sel,        // Divider code
	input  wire       xtal_div_tick,  // Same-domain pulse, crystal rate
	input  wire       rtc_tick,       // Same-domain pulse, watch rate
	input  wire       ext_clk_pin,    // Asynchronous external clock pin
	output reg        pwm_tick,       // One PWM clock has started
	output reg        half_tick       // Middle of the current PWM clock
);

	reg       ext_meta;               // First synchroniser stage
	reg       ext_sync;               // Second synchroniser stage
	reg       ext_prev;               // Edge detector history
	reg [5:0] div_cnt;                // Source ticks within a PWM clock
	reg [5:0] last;                   // Terminal count of divider
	reg       src_tick;               // Selected source pulse

	// Terminal count and source pulse selection
	always @* begin
		case (div_sel)
			2'h0:    last = `MPSD_DIV1_LAST;
			2'h1:    last = `MPSD_DIV4_LAST;
			2'h2:    last = `MPSD_DIV16_LAST;
			default: last = `MPSD_DIV64_LAST;
		endcase
		case (src_sel)
			`MPSD_SRC_XTAL_DIV: src_tick = xtal_div_tick;
			`MPSD_SRC_RTC:      src_tick = rtc_tick;
			`MPSD_SRC_EXT_PIN:  src_tick = ext_sync & ~ext_prev;
			default:            src_tick = 1'b1;
		endcase
	end

	// Pin synchroniser; edges are taken only past the second stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_meta <= ext_clk_pin;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// Divider; undivided clocks take their half mark one pclk later
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt   <= 6'h00;
			pwm_tick  <= 1'b0;
			half_tick <= 1'b0;
		end else if (clear) begin
			div_cnt   <= 6'h00;
			pwm_tick  <= 1'b0;
			half_tick <= 1'b0;
		end else begin
			pwm_tick  <= src_tick && (div_cnt == last);
			if (last == `MPSD_DIV1_LAST)
				half_tick <= pwm_tick;
			else
				half_tick <= src_tick && (div_cnt == {1'b0, last[5:1]});
			if (src_tick)
				div_cnt <= (div_cnt == last) ? 6'h00 : div_cnt + 6'h01;
		end
	end

endmodule

// file: rtl/mpsd_sd_channel.v
// First-order sigma-delta accumulator for one density output
`timescale 1ns/1ps

module mpsd_sd_channel #(
	parameter W = 16                  // Accumulator width
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         clear,        // Restart the accumulator
	input  wire         step,         // One PWM clock
	input  wire [W-1:0] value,        // Density, highs per 2^W clocks
	output wire         carry         // Output level for this clock
);

	reg  [W-1:0] acc;                 // Running remainder
	wire [W:0]   sum;                 // Remainder plus density

	// Carry out of the sum is the density bit; exact over 2^W clocks
	assign sum   = {1'b0, acc} + {1'b0, value};
	assign carry = sum[W];

	// Accumulate once per PWM clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			acc <= {W{1'b0}};
		else if (clear)
			acc <= {W{1'b0}};
		else if (step)
			acc <= sum[W-1:0];
	end

endmodule

// file: rtl/mpsd_top.v
// Multimode PWM and sigma-delta generator with APB register slave
`timescale 1ns/1ps
`include "mpsd_consts.vh"

module mpsd_top (
	input  wire                   pclk,
	input  wire                   presetn,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [`MPSD_ADDR_W-1:0] paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output reg                    pready,
	output reg                    pslverr,
	input  wire                   xtal_div_tick,
	input  wire                   rtc_tick,
	input  wire                   ext_clk_pin,
	output reg                    first_output,
	output reg                    first_output_en,
	output reg                    second_output,
	output reg                    second_output_en
);

	// Programmed registers
	reg  [6:0]  pulse_unit_control;      // Mode, divider and source
	reg  [7:0]  pulse_width_low_byte;    // Visible pulse width low
	reg  [7:0]  pulse_width_high_byte;   // Visible pulse width high
	reg  [7:0]  cycle_width_low_byte;    // Visible cycle width low
	reg  [7:0]  cycle_width_high_byte;   // Visible cycle width high
	reg  [7:0]  pw_hold;                 // Hidden low byte, pulse width
	reg  [7:0]  cw_hold;                 // Hidden low byte, cycle width

	// Values in use by the current cycle
	reg  [15:0] act_pw;                  // Active pulse width
	reg  [15:0] act_cw;                  // Active cycle width

	// Counters
	reg  [15:0] cnt;                     // Main PWM counter
	reg  [7:0]  cnt_b;                   // Second counter, dual 8-bit only

	// Bus decode
	wire [9:0]  idx;                     // Word index of access
	wire        setup;                   // APB setup phase
	wire        wr_en;                   // Write takes effect now
	reg         mapped;                  // Index hits a register
	reg  [31:0] rd_mux;                  // Read data for the index

	// Mode decode
	wire [2:0]  mode_select_field;
	wire [1:0]  clock_prescale_field;
	wire [1:0]  clock_source_field;
	wire        is16;                    // A 16-bit mode is selected
	wire        active;                  // Pins are driven
	wire        ctrl_wr;                 // Control register written

	// Timing
	wire        tick;                    // PWM clock enable
	wire        half;                    // Mid PWM clock enable
	wire [1:0]  sd_bit;                  // Density bits, both channels
	wire [15:0] sd_val [0:1];            // Density values, both channels

	// Cycle sequencing
	reg         wrap_a;                  // Main counter wraps this tick
	reg         wrap_b;                  // Second counter wraps this tick
	reg         end_a;                   // Low half of values may load
	reg         end_b;                   // High half of values may load
	reg  [15:0] next_cnt;
	reg  [7:0]  next_cnt_b;
	reg         next_first;
	reg         next_second;
	reg         fresh;                   // Cycle after a control write
	reg  [15:0] lvl_cnt;                 // Count the next levels are for
	reg  [7:0]  lvl_cnt_b;               // Second count the levels are for

	assign idx                  = paddr[`MPSD_ADDR_W-1:2];
	assign setup                = psel & ~penable;
	assign wr_en                = psel & penable & pready & pwrite;
	assign ctrl_wr              = wr_en && (idx == `MPSD_IDX_CTRL);
	assign mode_select_field    = pulse_unit_control[`MPSD_MODE_HI:`MPSD_MODE_LO];
	assign clock_prescale_field = pulse_unit_control[`MPSD_DIV_HI:`MPSD_DIV_LO];
	assign clock_source_field   = pulse_unit_control[`MPSD_SRC_HI:`MPSD_SRC_LO];
	assign is16   = (mode_select_field == `MPSD_MODE_SINGLE16) ||
	                (mode_select_field == `MPSD_MODE_TWIN16) ||
	                (mode_select_field == `MPSD_MODE_DENS_NRZ) ||
	                (mode_select_field == `MPSD_MODE_DENS_RZ);
	assign active = (mode_select_field != `MPSD_MODE_OFF) &&
	                (mode_select_field != `MPSD_MODE_PARK);

	// Read mux; unmapped indices answer with an error and zero data
	always @* begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (idx)
			`MPSD_IDX_CTRL:   rd_mux = {25'h0, pulse_unit_control};
			`MPSD_IDX_PW_LO:  rd_mux = {24'h0, pulse_width_low_byte};
			`MPSD_IDX_PW_HI:  rd_mux = {24'h0, pulse_width_high_byte};
			`MPSD_IDX_CW_LO:  rd_mux = {24'h0, cycle_width_low_byte};
			`MPSD_IDX_CW_HI:  rd_mux = {24'h0, cycle_width_high_byte};
			`MPSD_IDX_STATUS: rd_mux = {14'h0, second_output, first_output, cnt};
			default:          mapped = 1'b0;
		endcase
	end

	// Slave answers in the first access cycle; no wait states
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			fresh   <= 1'b0;
		end else begin
			fresh   <= ctrl_wr; // Counter restarts at zero, start levels owed
			pready  <= setup;
			pslverr <= setup & ~mapped;
			if (setup)
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	// Register writes; low bytes of 16-bit modes park in the hidden byte
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_unit_control    <= `MPSD_RST_CTRL;
			pulse_width_low_byte  <= `MPSD_RST_BYTE;
			pulse_width_high_byte <= `MPSD_RST_BYTE;
			cycle_width_low_byte  <= `MPSD_RST_BYTE;
			cycle_width_high_byte <= `MPSD_RST_BYTE;
			pw_hold               <= `MPSD_RST_BYTE;
			cw_hold               <= `MPSD_RST_BYTE;
		end else if (wr_en) begin
			case (idx)
				`MPSD_IDX_CTRL: begin
					pulse_unit_control <= pwdata[6:0];
				end
				`MPSD_IDX_PW_LO: begin
					if (is16)
						pw_hold <= pwdata[7:0];
					else
						pulse_width_low_byte <= pwdata[7:0];
				end
				`MPSD_IDX_PW_HI: begin
					pulse_width_high_byte <= pwdata[7:0];
					if (is16)
						pulse_width_low_byte <= pw_hold;
				end
				`MPSD_IDX_CW_LO: begin
					if (is16)
						cw_hold <= pwdata[7:0];
					else
						cycle_width_low_byte <= pwdata[7:0];
				end
				`MPSD_IDX_CW_HI: begin
					cycle_width_high_byte <= pwdata[7:0];
					if (is16)
						cycle_width_low_byte <= cw_hold;
				end
				default: begin
				end
			endcase
		end
	end

	// Prescaled PWM clock, shared by both outputs
	mpsd_prescale u_prescale (
		.pclk          (pclk),
		.presetn       (presetn),
		.clear         (ctrl_wr),
		.src_sel       (clock_source_field),
		.div_sel       (clock_prescale_field),
		.xtal_div_tick (xtal_div_tick),
		.rtc_tick      (rtc_tick),
		.ext_clk_pin   (ext_clk_pin),
		.pwm_tick      (tick),
		.half_tick     (half)
	);

	// Density channels: pulse width feeds the first, cycle width the second
	assign sd_val[0] = act_pw;
	assign sd_val[1] = act_cw;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_sd
			mpsd_sd_channel #(
				.W (16)
			) u_sd (
				.pclk    (pclk),
				.presetn (presetn),
				.clear   (ctrl_wr),
				.step    (tick),
				.value   (sd_val[ch]),
				.carry   (sd_bit[ch])
			);
		end
	endgenerate

	// Wrap and cycle-end decisions per mode
	always @* begin
		wrap_a = 1'b0;
		wrap_b = 1'b0;
		case (mode_select_field)
			`MPSD_MODE_SINGLE16: wrap_a = (cnt >= act_cw);
			`MPSD_MODE_TWIN8:    wrap_a = (cnt[7:0] >= act_cw[7:0]);
			`MPSD_MODE_TWIN16:   wrap_a = (cnt == `MPSD_CNT_TOP);
			`MPSD_MODE_DUAL8: begin
				wrap_a = (cnt[7:0] >= act_cw[7:0]);
				wrap_b = (cnt_b >= act_cw[15:8]);
			end
			default: ;
		endcase
		// Density modes treat each PWM clock as a whole cycle
		if ((mode_select_field == `MPSD_MODE_DENS_NRZ) ||
		    (mode_select_field == `MPSD_MODE_DENS_RZ)) begin
			end_a = 1'b1;
			end_b = 1'b1;
		end else if (mode_select_field == `MPSD_MODE_DUAL8) begin
			end_a = wrap_a;
			end_b = wrap_b;
		end else begin
			end_a = wrap_a;
			end_b = wrap_a;
		end
		next_cnt   = wrap_a ? 16'h0000 : cnt + 16'h0001;
		next_cnt_b = wrap_b ? 8'h00 : cnt_b + 8'h01;
	end

	// Counters; a control write or the parked mode holds them at zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt   <= 16'h0000;
			cnt_b <= 8'h00;
		end else if (ctrl_wr || !active) begin
			cnt   <= 16'h0000;
			cnt_b <= 8'h00;
		end else if (tick) begin
			cnt   <= next_cnt;
			cnt_b <= next_cnt_b;
		end
	end

	// Active values load at cycle end, so a cycle never sees a half update
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_pw <= 16'h0000;
			act_cw <= 16'h0000;
		end else if (ctrl_wr) begin
			act_pw <= {pulse_width_high_byte, pulse_width_low_byte};
			act_cw <= {cycle_width_high_byte, cycle_width_low_byte};
		end else if (tick) begin
			if (end_a) begin
				act_pw[7:0] <= pulse_width_low_byte;
				act_cw[7:0] <= cycle_width_low_byte;
			end
			if (end_b) begin
				act_pw[15:8] <= pulse_width_high_byte;
				act_cw[15:8] <= cycle_width_high_byte;
			end
		end
	end

	// Output levels for the next PWM clock; a compare clear beats the rise
	always @* begin
		next_first  = first_output;
		next_second = second_output;
		lvl_cnt     = fresh ? cnt : next_cnt; // Zero after a restart, else the next count
		lvl_cnt_b   = fresh ? cnt_b : next_cnt_b;
		case (mode_select_field)
			`MPSD_MODE_SINGLE16: begin
				if (lvl_cnt == 16'h0000)
					next_first = 1'b1;
				if (lvl_cnt == act_pw)
					next_first = 1'b0;
				next_second = 1'b0;
			end
			`MPSD_MODE_TWIN8: begin
				if (lvl_cnt[7:0] == 8'h00)
					next_first = 1'b1;
				if (lvl_cnt[7:0] == act_pw[7:0])
					next_first = 1'b0;
				if (lvl_cnt[7:0] == act_cw[15:8])
					next_second = 1'b1;
				if (lvl_cnt[7:0] == act_pw[15:8])
					next_second = 1'b0;
			end
			`MPSD_MODE_TWIN16: begin
				if (lvl_cnt == 16'h0000) begin
					next_first  = 1'b1;
					next_second = 1'b1;
				end
				if (lvl_cnt == act_pw)
					next_first = 1'b0;
				if (lvl_cnt == act_cw)
					next_second = 1'b0;
			end
			`MPSD_MODE_DUAL8: begin
				if (lvl_cnt[7:0] == 8'h00)
					next_first = 1'b1;
				if (lvl_cnt[7:0] == act_pw[7:0])
					next_first = 1'b0;
				if (lvl_cnt_b == 8'h00)
					next_second = 1'b1;
				if (lvl_cnt_b == act_pw[15:8])
					next_second = 1'b0;
			end
			`MPSD_MODE_DENS_NRZ,
			`MPSD_MODE_DENS_RZ: begin
				next_first  = sd_bit[0];
				next_second = sd_bit[1];
			end
			default: begin
				next_first  = 1'b0;
				next_second = 1'b0;
			end
		endcase
	end

	// Pin drivers; return-to-zero drops a high at mid clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_output     <= 1'b0;
			second_output    <= 1'b0;
			first_output_en  <= 1'b0;
			second_output_en <= 1'b0;
		end else begin
			first_output_en  <= active;
			second_output_en <= active;
			if (!active || ctrl_wr) begin
				first_output  <= 1'b0;
				second_output <= 1'b0;
			end else if (tick || fresh) begin
				first_output  <= next_first;
				second_output <= next_second;
			end else if (half && (mode_select_field == `MPSD_MODE_DENS_RZ)) begin
				first_output  <= 1'b0;
				second_output <= 1'b0;
			end
		end
	end

endmodule

// file: verification/mpsd_monitor.sv
// Port checker for the multimode pulse and density modulator
`timescale 1ns/1ps

module mpsd_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        first_output,
	input wire logic        first_output_en,
	input wire logic        second_output,
	input wire logic        second_output_en
);
	wire       ctrl_wr;                // Control write completes this edge
	reg  [2:0] mode_q;                 // Mode as last written by software
	reg  [1:0] div_q;                  // Divider as last written by software
	wire [6:0] rz_lim;                 // Half a PWM clock, in pclk

	assign rz_lim = (div_q == 2'h1) ? 7'h02 : ((div_q == 2'h2) ? 7'h08 : 7'h20);
	reg  [6:0] run_len;                // High run of the first output, in pclk

	assign ctrl_wr = psel && penable && pready && pwrite && (paddr == 12'h2b8);

	// Track mode and high run; a control write restarts the run count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q  <= 3'h0;
			div_q   <= 2'h0;
			run_len <= 7'h00;
		end else begin
			if (ctrl_wr) begin
				mode_q <= pwdata[6:4];
				div_q  <= pwdata[3:2];
			end
			if (!first_output || ctrl_wr)
				run_len <= 7'h00;
			else if (run_len != 7'h7f)
				run_len <= run_len + 7'h01;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_READY_AFTER_SETUP: assert property ((psel && !penable) |=> pready)
		else $error("pready missing after setup");
	AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable))
		else $error("pready without setup");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr outside access");
	AST_ERR_UNMAPPED: assert property ((psel && !penable && paddr == 12'h000) |=> pslverr)
		else $error("unmapped access not refused");
	AST_OFF_RELEASE: assert property ((ctrl_wr && pwdata[6:4] == 3'h0) |-> ##[1:3]
		(!first_output_en && !second_output_en)) else $error("mode zero still drives");
	AST_PARK_RELEASE: assert property ((ctrl_wr && pwdata[6:4] == 3'h7) |-> ##[1:3]
		(!first_output_en && !second_output_en)) else $error("mode seven still drives");
	AST_DRIVE_ON: assert property ((ctrl_wr && pwdata[6:4] != 3'h0 &&
		pwdata[6:4] != 3'h7) |-> ##[1:4] first_output_en) else $error("active mode not driving");
	AST_CTRL_CLEAR: assert property (ctrl_wr |=> (!first_output && !second_output))
		else $error("outputs not cleared by control write");
	AST_RZ_HALF: assert property ((mode_q == 3'h6 && div_q != 2'h0) |-> (run_len <= rz_lim))
		else $error("return to zero high too long");

	// Main scenarios reached
	cover property (ctrl_wr && pwdata[6:4] == 3'h3);
	cover property (ctrl_wr && pwdata[6:4] == 3'h6);
	cover property (pslverr);
endmodule

bind mpsd_top mpsd_monitor mpsd_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .first_output(first_output), .first_output_en(first_output_en),
	.second_output(second_output), .second_output_en(second_output_en));

// file: verification/mpsd_pin_load.sv
// Load model: the two port pins with pull-up resistors
`timescale 1ns/1ps

module mpsd_pin_load (
	input  wire logic first_output,
	input  wire logic first_output_en,
	input  wire logic second_output,
	input  wire logic second_output_en,
	output wire logic pin_a,
	output wire logic pin_b
);
	// A released pin floats up to the pull-up level, it never keeps old data
	assign pin_a = first_output_en ? first_output : 1'b1;
	assign pin_b = second_output_en ? second_output : 1'b1;
endmodule

// file: verification/tb.sv
// Self-checking bench for the multimode pulse and density modulator
`timescale 1ns/1ps

module tb;
	logic        pclk, presetn, psel, penable, pwrite, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire  [31:0] prdata;
	wire         pready, pslverr, o1, o1_en, o2, o2_en, pin_a, pin_b;
	logic        xtal_tick, rtc_tick, ext_pin;  // Other sources, held low except rtc_tick in the source test
	int          num_errors, n_checks, h1, h2, r1, run, mrun;

	mpsd_top mpsd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .xtal_div_tick(xtal_tick), .rtc_tick(rtc_tick),
		.ext_clk_pin(ext_pin), .first_output(o1), .first_output_en(o1_en),
		.second_output(o2), .second_output_en(o2_en));
	mpsd_pin_load mpsd_pin_load_i (.first_output(o1), .first_output_en(o1_en),
		.second_output(o2), .second_output_en(o2_en), .pin_a(pin_a), .pin_b(pin_b));

	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Counts, then the verdict
	task finish_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 16) begin
			num_errors++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Control write, clock source is every pclk
	task ctrl(input logic [2:0] m, input logic [1:0] dv);
		apb(1'b1, 12'h2b8, {25'h0, m, dv, 2'h3});
	endtask

	// Low byte first, high byte commits the pair
	task set_regs(input logic [15:0] pw, input logic [15:0] cw);
		apb(1'b1, 12'h2c4, {24'h0, pw[7:0]});
		apb(1'b1, 12'h2c8, {24'h0, pw[15:8]});
		apb(1'b1, 12'h2cc, {24'h0, cw[7:0]});
		apb(1'b1, 12'h2d0, {24'h0, cw[15:8]});
	endtask

	// Sample pins n cycles: highs, rises and longest high run of pin_a
	task count(input int n);
		logic p;
		p = pin_a;
		h1 = 0;
		h2 = 0;
		r1 = 0;
		run = 0;
		mrun = 0;
		repeat (n) begin
			@(posedge pclk);
			#1;
			h1 += pin_a;
			h2 += pin_b;
			r1 += (pin_a && !p);
			run = pin_a ? run + 1 : 0;
			mrun = (run > mrun) ? run : mrun;
			p = pin_a;
		end
	endtask

	// Reset values, refused access, released pins
	task t_reset;
		logic [11:0] a;
		for (a = 12'h2b8; a <= 12'h2d4; a += 12'h004) begin
			apb(1'b0, a, 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b1, 12'h000, 32'h5a);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		chk({30'h0, pin_a, pin_b}, 32'h3);
		$display("reset test done");
	endtask

	// Parked mode holds the counter and frees the pins
	task t_park;
		ctrl(3'h7, 2'h0);
		repeat (4) @(posedge pclk);
		apb(1'b0, 12'h2d4, 32'h0);
		chk({16'h0, rd[15:0]}, 32'h0);
		chk({30'h0, o1_en, o2_en}, 32'h0);
		$display("park test done");
	endtask

	// Twin 16-bit: bursts at start and after rollover, hidden low byte
	task t_twin16;
		set_regs(16'h0002, 16'h0005);
		ctrl(3'h3, 2'h0);
		count(65541);
		chk(h1, 4);
		chk(h2, 10);
		chk(r1, 1);
		apb(1'b1, 12'h2c4, 32'h55);
		apb(1'b0, 12'h2c4, 32'h0);
		chk(rd, 32'h02);
		apb(1'b1, 12'h2c8, 32'h0);
		apb(1'b0, 12'h2c4, 32'h0);
		chk(rd, 32'h55);
		apb(1'b0, 12'h2d4, 32'h0);
		chk({31'h0, rd[15:0] > 16'h0005}, 32'h1);
		$display("twin 16-bit test done");
	endtask

	// Single output, period 10, three highs per period
	task t_single;
		set_regs(16'h0003, 16'h0009);
		ctrl(3'h1, 2'h0);
		repeat (10) @(posedge pclk);
		count(40);
		chk(h1, 12);
		chk(r1, 4);
		$display("single test done");
	endtask

	// Twin 8-bit: common period 10, second output from 2 to 6
	task t_twin8;
		set_regs(16'h0604, 16'h0209);
		ctrl(3'h2, 2'h0);
		repeat (10) @(posedge pclk);
		count(40);
		chk(h1, 16);
		chk(h2, 16);
		$display("twin 8-bit test done");
	endtask

	// Dual 8-bit: periods 5 and 10, duties 2 and 7
	task t_dual8;
		set_regs(16'h0702, 16'h0904);
		ctrl(3'h5, 2'h0);
		repeat (10) @(posedge pclk);
		count(40);
		chk(h1, 16);
		chk(h2, 28);
		$display("dual 8-bit test done");
	endtask

	// Density: one quarter and one sixteenth, highs spread out
	task t_density;
		set_regs(16'h4000, 16'h1000);
		ctrl(3'h4, 2'h0);
		repeat (10) @(posedge pclk);
		count(64);
		chk(h1, 16);
		chk(h2, 4);
		chk(mrun, 1);
		set_regs(16'h4001, 16'h1000);
		ctrl(3'h6, 2'h1);
		repeat (12) @(posedge pclk);
		count(128);
		chk(r1, 8);
		chk({31'h0, mrun < 4}, 32'h1);
		$display("density test done");
	endtask

	// Watch-rate source held high, divided by 16: 16 pclk per count
	task t_source;
		rtc_tick <= 1'b1;
		set_regs(16'h0002, 16'h0003);
		apb(1'b1, 12'h2b8, {25'h0, 3'h3, 2'h2, 2'h1});
		count(40);
		chk(h1, 32);
		chk(h2, 40);
		rtc_tick <= 1'b0;
		$display("source test done");
	endtask

	// Back to mode zero releases the pins
	task t_off;
		ctrl(3'h0, 2'h0);
		repeat (4) @(posedge pclk);
		chk({30'h0, pin_a, pin_b}, 32'h3);
		$display("off test done");
	endtask

	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		xtal_tick = 1'b0;
		rtc_tick = 1'b0;
		ext_pin = 1'b0;
		num_errors = 0;
		n_checks = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_park();
		t_twin16();
		t_single();
		t_twin8();
		t_dual8();
		t_density();
		t_source();
		t_off();
		finish_test();
	end
endmodule
